// ### bench/filter_tuning_nvm_selftest_regs_test.sv
// Testbench: host model drives the register bank, reads checked by queue
`timescale 1ns/1ps
module filter_tuning_nvm_selftest_regs_test;
   import ftn_pkg::*;
   logic mclk, rst, reg_wr, reg_rd, rc_pulse, tune_en, ign, man_ov;
   logic fuse_prog, use_stored, rd_d, io, mo;
   logic [4:0] reg_addr;
   logic [23:0] reg_wdata, reg_rdata;
   logic [3:0] man_fine, fuse_addr, fine_code, last_fine, ef;
   logic [15:0] nvm, seed, v;
   logic [28:0] exp_q[$];
   logic [28:0] head;
   int n_errors, checks;
   logic [14:0] per[4] = '{15'h03E8, 15'h03E8, 15'h61A8, 15'h03E8};
   logic [8:0] cor[4] = '{9'h1FE, 9'h000, 9'h000, 9'h1F0};
   logic [3:0] fx[4] = '{4'h2, 4'h4, 4'hB, 4'h0};
   int nh[4] = '{5, 5, 3, 2};
   logic [4:0] ra[5] = '{REG_REF_PERIOD, REG_CORRECTION, REG_PROG_ALLOW,
      REG_BIT_INDEX, REG_SELFTEST_CTL};
   logic [23:0] rm[5] = '{24'h007FFF, 24'h0001FF, 24'h000001, 24'h00000F,
      24'h000001};
   logic [4:0] za[7] = '{REG_SPARE, REG_TUNE_STROBE, REG_PROG_PULSE,
      REG_SELFTEST_RES, REG_TUNE_STATUS, REG_RAW_COUNT, 5'h10};

   ftn_regs DUT (.MCLK(mclk), .RST(rst), .REG_WR(reg_wr), .REG_RD(reg_rd),
      .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
      .RC_PULSE(rc_pulse), .TUNE_ENABLE(tune_en), .IGNORE_STORED(ign),
      .MANUAL_OVERRIDE(man_ov), .MANUAL_FINE(man_fine), .NVM_BITS(nvm),
      .FUSE_PROG(fuse_prog), .FUSE_ADDR(fuse_addr), .FINE_CODE(fine_code),
      .USE_STORED(use_stored));
   ftn_host u_host (.clk(mclk), .wr(reg_wr), .rd(reg_rd), .addr(reg_addr),
      .wdata(reg_wdata));

   // ==========================================================
   // Clock and helpers
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   // Signature: count bits low first into a shift-left CRC
   function automatic logic [15:0] crc24(input logic [23:0] c);
      logic [15:0] r;
      r = CRC_INIT;
      for (int i = 0; i < 24; i++) begin
         r = {r[14:0], 1'b0} ^ ((r[15] ^ c[i]) ? CRC_POLY : 16'h0000);
      end
      return r;
   endfunction : crc24
   task automatic chk(input string nm, input logic [23:0] e, g);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic rd(input logic [4:0] a, input logic [23:0] e);
      exp_q.push_back({a, e});
      u_host.read(a);
   endtask : rd
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : report_and_stop
   // Oldest note against the data one edge after the read strobe
   always @(posedge mclk) begin
      rd_d <= reg_rd;
      if (rd_d && exp_q.size() > 0) begin
         head = exp_q.pop_front();
         chk($sformatf("register %h", head[28:24]), head[23:0], reg_rdata);
      end
   end
   // Tuning run: busy during, count and fine code after
   task automatic run_tune(input logic [14:0] p, input logic [8:0] c,
      input int n, input logic [3:0] f, input logic st);
      u_host.start_tune(p, c);
      rd(REG_TUNE_STATUS, {19'h0, 1'b1, last_fine});
      if (st) rd(REG_SELFTEST_RES, 24'h010000);
      @(posedge mclk);
      rc_pulse <= 1'b1;
      repeat (n) @(posedge mclk);
      rc_pulse <= 1'b0;
      repeat (3) @(posedge mclk);
      rd(REG_TUNE_STATUS, {20'h0, f});
      rd(REG_RAW_COUNT, 24'(p * n));
      if (st) repeat (30) @(posedge mclk);
      if (st) rd(REG_SELFTEST_RES, {8'h0, crc24(24'(p * n))});
      last_fine = f;
      chk("fine code", {20'h0, f}, {20'h0, fine_code});
   endtask : run_tune

   // ==========================================================
   // Main sequence
   initial begin
      rst = 1'b1;
      {rc_pulse, tune_en, ign, man_ov, rd_d} = 5'h0C;
      {man_fine, last_fine, nvm, seed} = {8'h00, 16'h0000, 16'h0017};
      {n_errors, checks} = 64'h0;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      foreach (za[i]) rd(za[i], 24'h0);
      foreach (ra[i]) rd(ra[i], 24'h0);
      foreach (ra[i]) begin
         seed = lfsr(seed);
         u_host.write(ra[i], {8'hA5, seed});
         rd(ra[i], {8'hA5, seed} & rm[i]);
      end
      u_host.write(REG_PROG_ALLOW, 24'h0);
      u_host.write(REG_SELFTEST_CTL, 24'h0);
      $display("register map test done");
      foreach (per[i]) run_tune(per[i], cor[i], nh[i], fx[i], 1'b0);
      @(posedge mclk);
      tune_en <= 1'b0;
      u_host.start_tune(15'h03E8, 9'h000);
      rd(REG_TUNE_STATUS, {20'h0, last_fine});
      tune_en <= 1'b1;
      u_host.write(REG_SELFTEST_CTL, 24'h1);
      run_tune(15'h03E8, 9'h000, 4, 4'h3, 1'b1);
      u_host.write(REG_SELFTEST_CTL, 24'h0);
      $display("tuning and self-test done");
      seed = lfsr(seed);
      u_host.program_bit(seed[3:0], 1'b0);
      @(posedge mclk);
      chk("fuse blocked", 24'h0, {23'h0, fuse_prog});
      u_host.program_bit(seed[3:0], 1'b1);
      @(posedge mclk);
      chk("fuse start", {20'h1, seed[3:0]},
         {19'h0, fuse_prog, fuse_addr});
      rd(REG_TUNE_STATUS, {18'h0, 2'b10, last_fine});
      for (int k = 0; k < 500 && fuse_prog !== 1'b0; k++) @(posedge mclk);
      if (fuse_prog !== 1'b0) begin
         n_errors++;
         $display("ERROR fuse busy expected 0 seen %b", fuse_prog);
         report_and_stop;
      end
      rd(REG_TUNE_STATUS, {20'h0, last_fine});
      $display("fuse programming done");
      for (int i = 0; i < 12; i++) begin
         seed = lfsr(seed);
         v = {seed[15:14], i[0], seed[12:0]};
         io = seed[14] & seed[2];
         mo = seed[7] & seed[6];
         ef = mo ? seed[11:8] : ((v[13] & ~io) ? v[3:0] : last_fine);
         @(posedge mclk);
         {nvm, ign, man_ov, man_fine} <= {v, io, mo, seed[11:8]};
         rd(REG_STORED, {8'h0, v});
         @(posedge mclk);
         chk("fine select", {19'h0, v[13] & ~io, ef},
            {19'h0, use_stored, fine_code});
      end
      $display("stored settings done");
      repeat (4) @(posedge mclk);
      report_and_stop;
   end
endmodule : filter_tuning_nvm_selftest_regs_test

// ### bench/ftn_host.sv
// Host model: parallel register master for the register bank
`timescale 1ns/1ps
module ftn_host (
   input wire logic clk,
   output logic wr,
   output logic rd,
   output logic [4:0] addr,
   output logic [ftn_pkg::DATA_W-1:0] wdata
);
   import ftn_pkg::*;
   // Idle bus at time zero
   initial begin
      wr = 1'b0;
      rd = 1'b0;
      addr = 5'h00;
      wdata = 24'h000000;
   end
   // One write; released lines flip so stale values never look valid
   task automatic write(input logic [4:0] a, input logic [23:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      addr <= ~a;
      wdata <= ~d;
   endtask : write
   task automatic read(input logic [4:0] a);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      addr <= ~a;
   endtask : read
   // Period in picoseconds, correction, then any value to the strobe
   task automatic start_tune(input logic [14:0] p, input logic [8:0] c);
      write(REG_REF_PERIOD, {9'h000, p});
      write(REG_CORRECTION, {15'h0000, c});
      write(REG_TUNE_STROBE, 24'h5A0F3C);
   endtask : start_tune
   // One fuse bit per step; caller waits for write-active to clear
   task automatic program_bit(input logic [3:0] idx, input logic allow);
      write(REG_PROG_ALLOW, {23'h000000, allow});
      write(REG_BIT_INDEX, {20'h00000, idx});
      write(REG_PROG_PULSE, 24'hA5C3E1);
   endtask : program_bit
endmodule : ftn_host

// ### bench/ftn_regs_checker.sv
// Checker: port assertions for the filter tuning register bank
`timescale 1ns/1ps
module ftn_regs_checker (
   input wire logic MCLK,
   input wire logic RST,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [4:0] REG_ADDR,
   input wire logic [ftn_pkg::DATA_W-1:0] REG_WDATA,
   input wire logic [ftn_pkg::DATA_W-1:0] REG_RDATA,
   input wire logic RC_PULSE,
   input wire logic TUNE_ENABLE,
   input wire logic IGNORE_STORED,
   input wire logic MANUAL_OVERRIDE,
   input wire logic [3:0] MANUAL_FINE,
   input wire logic [15:0] NVM_BITS,
   input wire logic FUSE_PROG,
   input wire logic [3:0] FUSE_ADDR,
   input wire logic [3:0] FINE_CODE,
   input wire logic USE_STORED
);
   import ftn_pkg::*;
   // ==========================================================
   // Helpers
   logic [1:0] up;
   logic [8:0] hi_cnt;
   wire stored_on = NVM_BITS[13] & ~IGNORE_STORED;
   // Settle flags keep $past from seeing values from inside reset
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         up <= 2'h0;
         hi_cnt <= 9'h000;
      end else begin
         up <= {up[0], 1'b1};
         hi_cnt <= FUSE_PROG ? hi_cnt + 9'h001 : 9'h000;
      end
   end
   default clocking @(posedge MCLK); endclocking
   default disable iff (RST);
   // ==========================================================
   // Assertions
   a_rdata_hold: assert property (!REG_RD |=> $stable(REG_RDATA))
      else $error("read data moved without a read");
   a_fuse_length: assert property (
      $fell(FUSE_PROG) |-> int'(hi_cnt) == NVM_PROG_CYCLES)
      else $error("fuse pulse length wrong");
   a_fuse_cause: assert property (
      $rose(FUSE_PROG) |-> $past(REG_WR) && $past(REG_ADDR) == REG_PROG_PULSE)
      else $error("fuse pulse without a pulse write");
   a_fuse_addr: assert property (
      FUSE_PROG && $past(FUSE_PROG) |-> $stable(FUSE_ADDR))
      else $error("fuse index moved during a pulse");
   a_use_stored: assert property (
      up[1] |-> USE_STORED == $past(stored_on))
      else $error("stored select wrong");
   a_fine_manual: assert property (
      up[1] && $past(MANUAL_OVERRIDE) |-> FINE_CODE == $past(MANUAL_FINE))
      else $error("manual fine code not used");
   a_fine_stored: assert property (
      up[1] && !$past(MANUAL_OVERRIDE) && $past(stored_on)
      && $past(stored_on, 2) |-> FINE_CODE == $past(NVM_BITS[3:0]))
      else $error("stored fine code not used");
   a_stored_read: assert property (
      up[1] && $past(REG_RD) && $past(REG_ADDR) == REG_STORED
      |-> REG_RDATA == {8'h00, $past(NVM_BITS)})
      else $error("stored read-back wrong");
endmodule : ftn_regs_checker

bind ftn_regs ftn_regs_checker u_chk (.MCLK(MCLK), .RST(RST),
   .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
   .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .RC_PULSE(RC_PULSE),
   .TUNE_ENABLE(TUNE_ENABLE), .IGNORE_STORED(IGNORE_STORED),
   .MANUAL_OVERRIDE(MANUAL_OVERRIDE), .MANUAL_FINE(MANUAL_FINE),
   .NVM_BITS(NVM_BITS), .FUSE_PROG(FUSE_PROG), .FUSE_ADDR(FUSE_ADDR),
   .FINE_CODE(FINE_CODE), .USE_STORED(USE_STORED));

// ### hdl/ftn_regs.sv
// Register bank for RC tuning, stored settings and tuning self-test
`timescale 1ns/1ps
module ftn_regs
   import ftn_pkg::*;
(
   input wire logic MCLK,
   input wire logic RST,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [4:0] REG_ADDR,
   input wire logic [ftn_pkg::DATA_W-1:0] REG_WDATA,
   output logic [ftn_pkg::DATA_W-1:0] REG_RDATA,
   input wire logic RC_PULSE,
   input wire logic TUNE_ENABLE,
   input wire logic IGNORE_STORED,
   input wire logic MANUAL_OVERRIDE,
   input wire logic [3:0] MANUAL_FINE,
   input wire logic [15:0] NVM_BITS,
   output logic FUSE_PROG,
   output logic [3:0] FUSE_ADDR,
   output logic [3:0] FINE_CODE,
   output logic USE_STORED
);
   import ftn_pkg::*;

   // ==========================================================
   // Register map: 24-bit words, unused bits read zero
   //   0x04 strobe, write only: any value starts a tuning run
   //   0x05 reference period in picoseconds, bits 14:0
   //   0x06 signed correction in 1024 ps steps, bits 8:0
   //   0x07 spare, reads zero, writes dropped
   //   0x08 status: fine code 3:0, tuning 4, fuse write 5
   //   0x09 raw count before correction, bits 23:0
   //   0x0A stored settings, a mirror of the fuse array
   //   0x0B fuse program allow, bit 0
   //   0x0C fuse bit index, bits 3:0
   //   0x0D fuse pulse, write only, contents ignored
   //   0x0E self-test mode, bit 0
   //   0x0F self-test signature 15:0, pending 16
   //
   // Hazards worth knowing
   //   A strobe while the engine is busy or disabled is lost; the
   //   host only learns this by polling the tuning flag.
   //   A fuse pulse during a fuse write is dropped, not queued, so
   //   a fuse never sees two overlapping pulses.
   //   Read data is captured on the read strobe, so a status poll
   //   shows the state at the strobe, not the live state.
   //   The filter fine code follows its inputs one edge late.
   //   Self-test signing ignores the enable: once started it ends.
   //   Counts saturate at all ones rather than wrap, so a stuck
   //   measurement window gives a clamped, not a small, code.
   //   The fuse array itself is outside; this bank only times the
   //   pulse and holds the index steady while it lasts.

   // ==========================================================
   // State of the bank
   typedef struct packed {
      logic [23:0] rdata;
      logic [14:0] period;
      logic [8:0] corr;
      logic allow;
      logic [3:0] bit_index;
      logic selftest;
      logic nvm_active;
      logic [15:0] nvm_cnt;
      logic [3:0] fuse_addr;
      logic [3:0] fine_out;
      logic use_stored;
   } ftn_regs_t;

   ftn_regs_t st;
   ftn_regs_t next_st;

   ftn_tune_if tif ();

   logic wr_strobe;
   logic wr_pulse;
   logic stored_ok;

   // ==========================================================
   // Tuning engine
   ftn_tune_engine u_engine (
      .clk(MCLK),
      .rst(RST),
      .rc_pulse(RC_PULSE),
      .t(tif.engine)
   );

   // Strobe writes carry no data meaning, only the event
   assign wr_strobe = REG_WR && (REG_ADDR == REG_TUNE_STROBE);
   assign wr_pulse = REG_WR && (REG_ADDR == REG_PROG_PULSE);

   // Engine controls come straight from the bank
   assign tif.start = wr_strobe;
   assign tif.enable = TUNE_ENABLE;
   assign tif.selftest = st.selftest;
   assign tif.period = st.period;
   assign tif.corr = st.corr;

   // Marker clear forces the ignore control on
   assign stored_ok = NVM_BITS[NVM_MARKER_BIT] && !IGNORE_STORED;

   // ==========================================================
   // Read data mux, also used to keep the decode in one place
   function automatic logic [23:0] read_mux(logic [4:0] a,
      ftn_regs_t s, logic active, logic pending, logic [23:0] cnt,
      logic [3:0] fine, logic [15:0] sig, logic [15:0] nvm);
      logic [23:0] d;
      d = 24'h000000;
      if (a == REG_REF_PERIOD) begin
         d[14:0] = s.period;
      end else if (a == REG_CORRECTION) begin
         d[8:0] = s.corr;
      end else if (a == REG_TUNE_STATUS) begin
         d[3:0] = fine;
         d[STAT_ACTIVE_BIT] = active;
         d[STAT_NVM_BIT] = s.nvm_active;
      end else if (a == REG_RAW_COUNT) begin
         d = cnt;
      end else if (a == REG_STORED) begin
         d[15:0] = nvm;
      end else if (a == REG_PROG_ALLOW) begin
         d[0] = s.allow;
      end else if (a == REG_BIT_INDEX) begin
         d[3:0] = s.bit_index;
      end else if (a == REG_SELFTEST_CTL) begin
         d[0] = s.selftest;
      end else if (a == REG_SELFTEST_RES) begin
         d[15:0] = sig;
         d[PENDING_BIT] = pending;
      end
      return d;
   endfunction : read_mux

   // ==========================================================
   // Next state of the bank
   always_comb begin
      next_st = st;

      // Host register writes; strobe and pulse offsets store nothing
      if (REG_WR) begin
         if (REG_ADDR == REG_REF_PERIOD) begin
            next_st.period = REG_WDATA[14:0];
         end else if (REG_ADDR == REG_CORRECTION) begin
            next_st.corr = REG_WDATA[8:0];
         end else if (REG_ADDR == REG_PROG_ALLOW) begin
            next_st.allow = REG_WDATA[0];
         end else if (REG_ADDR == REG_BIT_INDEX) begin
            next_st.bit_index = REG_WDATA[3:0];
         end else if (REG_ADDR == REG_SELFTEST_CTL) begin
            next_st.selftest = REG_WDATA[0];
         end
      end

      // Fuse write: a pulse while busy or not allowed is dropped
      if (st.nvm_active) begin
         if (st.nvm_cnt == 16'(NVM_PROG_CYCLES - 1)) begin
            next_st.nvm_active = 1'b0;
            next_st.nvm_cnt = 16'h0000;
         end else begin
            next_st.nvm_cnt = st.nvm_cnt + 16'h0001;
         end
      end else if (wr_pulse && st.allow) begin
         next_st.nvm_active = 1'b1;
         next_st.nvm_cnt = 16'h0000;
         next_st.fuse_addr = st.bit_index;
      end

      // Read data is sampled on the read strobe and held
      if (REG_RD) begin
         next_st.rdata = read_mux(REG_ADDR, st, tif.tune_active,
            tif.pending, tif.count, tif.fine, tif.signature, NVM_BITS);
      end

      // Fine code actually driven to the filter
      if (MANUAL_OVERRIDE) begin
         next_st.fine_out = MANUAL_FINE;
      end else if (stored_ok) begin
         next_st.fine_out = NVM_BITS[NVM_FINE_LSB+3:NVM_FINE_LSB];
      end else begin
         next_st.fine_out = tif.fine;
      end
      next_st.use_stored = stored_ok;
   end

   // ==========================================================
   // State register
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         st <= '0;
         st.period <= PERIOD_RST;
         st.corr <= CORR_RST;
      end else begin
         st <= next_st;
      end
   end

   // ==========================================================
   // Outputs, all from flip-flops
   assign REG_RDATA = st.rdata;
   assign FUSE_PROG = st.nvm_active;
   assign FUSE_ADDR = st.fuse_addr;
   assign FINE_CODE = st.fine_out;
   assign USE_STORED = st.use_stored;
endmodule : ftn_regs

// ### hdl/ftn_tune_engine.sv
// RC tuning engine: period counter, corrected decode and CRC self-test
`timescale 1ns/1ps
module ftn_tune_engine
   import ftn_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic rc_pulse,
   ftn_tune_if.engine t
);
   import ftn_pkg::*;

   typedef struct packed {
      ftn_state_t state;
      logic tune_active;
      logic pending;
      logic sig_mode;
      logic [23:0] acc;
      logic [23:0] count;
      logic [3:0] fine;
      logic [15:0] crc;
      logic [15:0] signature;
      logic [4:0] bit_idx;
   } ftn_eng_t;

   ftn_eng_t st;
   ftn_eng_t next_st;

   // ==========================================================
   // Helpers
   // Saturating add so a stuck RC pulse cannot wrap the count
   function automatic logic [23:0] sat_add(logic [23:0] a,
      logic [14:0] b);
      logic [24:0] s;
      s = {1'b0, a} + {10'h000, b};
      return s[24] ? 24'hFFFFFF : s[23:0];
   endfunction : sat_add

   // Apply the signed correction in 1.024 ns steps, then clamp
   function automatic logic [3:0] decode_fine(logic [23:0] cnt,
      logic [8:0] corr);
      logic signed [25:0] adj;
      adj = signed'({2'b00, cnt})
         + (signed'({{17{corr[8]}}, corr}) <<< CORR_SHIFT);
      if (adj < 0) begin
         return 4'h0;
      end else if (adj[25:CORR_SHIFT] > 16'(FINE_MAX)) begin
         return FINE_MAX;
      end
      return adj[CORR_SHIFT+3:CORR_SHIFT];
   endfunction : decode_fine

   function automatic logic [15:0] crc_step(logic [15:0] c, logic d);
      return (c[15] ^ d) ? ({c[14:0], 1'b0} ^ CRC_POLY)
         : {c[14:0], 1'b0};
   endfunction : crc_step

   // ==========================================================
   // Next state
   always_comb begin
      next_st = st;
      case (st.state)
         FTN_IDLE: begin
            if (t.start && t.enable) begin
               next_st.state = FTN_WAIT_HI;
               next_st.tune_active = 1'b1;
               next_st.pending = t.selftest;
               next_st.sig_mode = t.selftest;
            end
         end
         FTN_WAIT_HI: begin
            if (!t.enable) begin
               next_st.state = FTN_IDLE;
               next_st.tune_active = 1'b0;
               next_st.pending = 1'b0;
            end else if (rc_pulse) begin
               next_st.state = FTN_MEASURE;
               next_st.acc = sat_add(24'h000000, t.period);
            end
         end
         FTN_MEASURE: begin
            if (!t.enable) begin
               next_st.state = FTN_IDLE;
               next_st.tune_active = 1'b0;
               next_st.pending = 1'b0;
            end else if (rc_pulse) begin
               next_st.acc = sat_add(st.acc, t.period);
            end else begin
               // Count and code land in the same edge the flag drops
               next_st.count = st.acc;
               next_st.fine = decode_fine(st.acc, t.corr);
               next_st.tune_active = 1'b0;
               next_st.crc = CRC_INIT;
               next_st.bit_idx = 5'h00;
               next_st.state = st.sig_mode ? FTN_SIGN : FTN_IDLE;
            end
         end
         FTN_SIGN: begin
            // One count bit per cycle, LSB first
            next_st.crc = crc_step(st.crc, st.count[st.bit_idx]);
            next_st.bit_idx = st.bit_idx + 5'h01;
            if (st.bit_idx == SIGN_LAST_BIT) begin
               next_st.signature = crc_step(st.crc,
                  st.count[st.bit_idx]);
               next_st.pending = 1'b0;
               next_st.state = FTN_IDLE;
            end
         end
         default: next_st.state = FTN_IDLE;
      endcase
   end

   // ==========================================================
   // State register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign t.tune_active = st.tune_active;
   assign t.pending = st.pending;
   assign t.count = st.count;
   assign t.fine = st.fine;
   assign t.signature = st.signature;
endmodule : ftn_tune_engine

// ### shared/ftn_pkg.sv
// Package: register map, field layout and timing for the filter tuning block
package ftn_pkg;
   // ==========================================================
   // Register offsets
   localparam logic [4:0] REG_TUNE_STROBE = 5'h04;
   localparam logic [4:0] REG_REF_PERIOD = 5'h05;
   localparam logic [4:0] REG_CORRECTION = 5'h06;
   localparam logic [4:0] REG_SPARE = 5'h07;
   localparam logic [4:0] REG_TUNE_STATUS = 5'h08;
   localparam logic [4:0] REG_RAW_COUNT = 5'h09;
   localparam logic [4:0] REG_STORED = 5'h0A;
   localparam logic [4:0] REG_PROG_ALLOW = 5'h0B;
   localparam logic [4:0] REG_BIT_INDEX = 5'h0C;
   localparam logic [4:0] REG_PROG_PULSE = 5'h0D;
   localparam logic [4:0] REG_SELFTEST_CTL = 5'h0E;
   localparam logic [4:0] REG_SELFTEST_RES = 5'h0F;

   // ==========================================================
   // Field positions and widths
   localparam int PERIOD_W = 15;
   localparam int CORR_W = 9;
   localparam int COUNT_W = 24;
   localparam int DATA_W = 24;
   localparam int STAT_ACTIVE_BIT = 4;
   localparam int STAT_NVM_BIT = 5;
   localparam int NVM_MARKER_BIT = 13;
   localparam int NVM_FINE_LSB = 0;
   localparam int PENDING_BIT = 16;
   localparam int CORR_SHIFT = 10;

   // ==========================================================
   // Reset values and limits
   localparam logic [14:0] PERIOD_RST = 15'h0000;
   localparam logic [8:0] CORR_RST = 9'h000;
   localparam logic [3:0] FINE_MAX = 4'hB;
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [15:0] CRC_POLY = 16'h1021;
   localparam logic [4:0] SIGN_LAST_BIT = 5'h17;

   // ==========================================================
   // Timing: fuse programming pulse
   localparam int CLK_PERIOD_NS = 25;
   localparam int NVM_PROG_TIME_NS = 10000;
   localparam int NVM_PROG_CYCLES =
      (NVM_PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ==========================================================
   // Tuning engine states
   typedef enum logic [1:0] {
      FTN_IDLE,
      FTN_WAIT_HI,
      FTN_MEASURE,
      FTN_SIGN
   } ftn_state_t;
endpackage : ftn_pkg

// ### shared/ftn_tune_if.sv
// Interface between the register bank and the tuning engine
`timescale 1ns/1ps
interface ftn_tune_if;
   logic start;
   logic enable;
   logic selftest;
   logic [14:0] period;
   logic [8:0] corr;
   logic tune_active;
   logic pending;
   logic [23:0] count;
   logic [3:0] fine;
   logic [15:0] signature;

   modport regs (output start, enable, selftest, period, corr,
      input tune_active, pending, count, fine, signature);
   modport engine (input start, enable, selftest, period, corr,
      output tune_active, pending, count, fine, signature);
endinterface : ftn_tune_if
